// File: eesr_params.svh
/*
 Constants for the serial EEPROM access block: bus control codes, address map,
 unlock keys and write-cycle timing.
 Assumes it is included by its bare name wherever these values are needed.
*/
`ifndef EESR_PARAMS_SVH
`define EESR_PARAMS_SVH

`define EESR_CTRL_EE     7'h57
`define EESR_CTRL_RTC    7'h6f
`define EESR_ARR_TOP     8'h7f
`define EESR_PROT_LO     8'hf0
`define EESR_PROT_HI     8'hf7
`define EESR_PROT_PAGE   5'h1e
`define EESR_RTC_TOP     8'h5f
`define EESR_UNLOCK_ADDR 8'h09
`define EESR_KEY1        8'h55
`define EESR_KEY2        8'haa
`define EESR_RSV_LO      16'hfffe
`define EESR_PTR_RST     8'h00
`define EESR_CLK_MHZ     10
`define EESR_TWC_US      5000
`define EESR_TWC_CYC     (`EESR_TWC_US * `EESR_CLK_MHZ)

`endif

// File: eesr_pkg.sv
/*
 Types shared by the serial EEPROM access block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eesr_pkg;

   typedef enum logic [3:0] {
      EESR_IDLE = 4'h0,
      EESR_CTRL = 4'h1,
      EESR_CACK = 4'h3,
      EESR_ADDR = 4'h2,
      EESR_AACK = 4'h6,
      EESR_WDAT = 4'h7,
      EESR_WACK = 4'h5,
      EESR_RDAT = 4'hb,
      EESR_RACK = 4'ha
   } eesr_state_t;

   typedef enum logic [1:0] {
      EESR_LOCKED = 2'h0,
      EESR_KEYED  = 2'h1,
      EESR_OPEN   = 2'h3
   } eesr_lock_t;

   typedef enum logic {
      EESR_SP_RTC = 1'b0,
      EESR_SP_EE  = 1'b1
   } eesr_space_t;

endpackage : eesr_pkg

// File: eesr_mem_if.sv
/*
 Carrier between the bus engine and the memory store of the EEPROM block.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface eesr_mem_if;
   logic       ld;
   logic [7:0] ld_addr;
   logic [7:0] ld_data;
   logic       clear;
   logic       commit;
   logic       busy;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;

   modport ctl (output ld, ld_addr, ld_data, clear, commit, rd_addr,
                input  busy, rd_data);
   modport mem (input  ld, ld_addr, ld_data, clear, commit, rd_addr,
                output busy, rd_data);
endinterface : eesr_mem_if

`default_nettype wire

// File: eesr_pin_sync.sv
/*
 Pin synchroniser and bus condition detector for the serial clock and data.
 Assumes both pins are asynchronous to mclk_i and slow against it.
*/
`timescale 1ns/100ps
`default_nettype none

module eesr_pin_sync
   import eesr_pkg::*;
(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // Raw pins
   input  wire logic scl_pin_i,
   input  wire logic sda_pin_i,
   // Conditions
   output logic      sda_o,
   output logic      scl_rise_o,
   output logic      scl_fall_o,
   output logic      start_o,
   output logic      stop_o
);

   logic scl_m_q, scl_s_q, scl_d_q;
   logic sda_m_q, sda_s_q, sda_d_q;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_d_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_m_q <= scl_pin_i;
         scl_s_q <= scl_m_q;
         scl_d_q <= scl_s_q;
         sda_m_q <= sda_pin_i;
         sda_s_q <= sda_m_q;
         sda_d_q <= sda_s_q;
      end
   end

   assign sda_o      = sda_s_q;
   assign scl_rise_o = scl_s_q & ~scl_d_q;
   assign scl_fall_o = ~scl_s_q & scl_d_q;
   // Data moving while the clock stays high marks a frame boundary.
   assign start_o    = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
   assign stop_o     = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

endmodule : eesr_pin_sync

`default_nettype wire

// File: eesr_mem.sv
/*
 Memory store: 128-byte array, 8-byte protected region, page buffer and
 internal write-cycle timer.
 Assumes the bus engine loads, clears and commits the buffer by strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eesr_params.svh"

module eesr_mem
   import eesr_pkg::*;
#(
   parameter int          TWC_CYC = `EESR_TWC_CYC,
   parameter int          VARIANT = 0,
   parameter logic [23:0] ORG_ID  = 24'h5a5a5a,
   parameter logic [23:0] EXT48   = 24'h010203,
   parameter logic [39:0] EXT64   = 40'h0102030405
)(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // Engine side
   eesr_mem_if.mem   mif
);

   logic [7:0]  arr_q [0:127];
   logic [7:0]  prot  [0:7];
   logic [7:0]  buf_q [0:7];
   logic [7:0]  bvld_q;
   logic [4:0]  page_q;
   logic [19:0] twc_q;

   // The organisation identifier and extension values are arbitrary.
   function automatic logic [7:0] factory_byte(input logic [2:0] idx);
      logic [63:0] img;
      logic [39:0] ext;
      ext = EXT64;
      if (ext[39:24] >= `EESR_RSV_LO) ext[39:24] = 16'h0000;
      img = 64'hffff_ffff_ffff_ffff;
      if (VARIANT == 1) img = {16'hffff, ORG_ID, EXT48};
      else if (VARIANT == 2) img = {ORG_ID, ext};
      factory_byte = img[{~idx, 3'b000} +: 8];
   endfunction : factory_byte

   // The factory image is reloaded on reset, so unlocked writes hold only until the next reset.
   for (genvar g = 0; g < 8; g++) begin : g_prot
      logic [7:0] byte_q;
      always_ff @(posedge mclk_i) begin
         if (reset_i) begin
            byte_q <= factory_byte(3'(g));
         end else if (mif.commit && page_q == `EESR_PROT_PAGE && bvld_q[g]) begin
            byte_q <= buf_q[g];
         end
      end
      assign prot[g] = byte_q;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || mif.clear || mif.commit) begin
         bvld_q <= 8'h00;
      end else if (mif.ld) begin
         bvld_q[mif.ld_addr[2:0]] <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         page_q <= 5'h00;
      end else if (mif.ld) begin
         page_q <= mif.ld_addr[7:3];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (mif.ld) begin
         buf_q[mif.ld_addr[2:0]] <= mif.ld_data;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (mif.commit && page_q != `EESR_PROT_PAGE) begin
         for (int i = 0; i < 8; i++) begin
            if (bvld_q[i]) arr_q[{page_q[3:0], 3'(i)}] <= buf_q[i];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         twc_q <= 20'h00000;
      end else if (mif.commit && bvld_q != 8'h00) begin
         twc_q <= 20'(TWC_CYC);
      end else if (twc_q != 20'h00000) begin
         twc_q <= twc_q - 20'h00001;
      end
   end

   assign mif.busy    = (twc_q != 20'h00000);
   assign mif.rd_data = mif.rd_addr[7] ? prot[mif.rd_addr[2:0]] : arr_q[mif.rd_addr[6:0]];

endmodule : eesr_mem

`default_nettype wire

// File: eesr_top.sv
/*
 Serial-bus slave for the EEPROM access path: sequential reads with a shared
 auto-incrementing pointer, page writes, and a key-guarded protected region.
 Assumes an external bus master drives the clock pin and a pull-up on data.
*/
// What this block does
// - Master acknowledge fetches the next byte.
// - Pointer advances after every data byte.
// - Pointer wraps from top to bottom.
// - Protected eight bytes share EEPROM control byte.
// - Protected bytes readable without unlocking.
// - Invalid address byte is not acknowledged.
// - Key register stores nothing, reads zero.
// - Wrong key sequence leaves region locked.
// - Region relocks after every EEPROM write.
// - Partial protected writes are accepted.
// - Short node address fills top six bytes.
// - Long node address fills all eight.
// - Long extension avoids two reserved prefixes.
// - One pointer serves both address spaces.
// - EEPROM commands refused during write cycle.
// - Address write loads pointer before restart.
// - Page writes wrap within eight bytes.
`timescale 1ns/100ps
`default_nettype none
`include "eesr_params.svh"

module eesr_top
   import eesr_pkg::*;
#(
   parameter int          TWC_CYC = `EESR_TWC_CYC,
   parameter int          VARIANT = 0,
   parameter logic [23:0] ORG_ID  = 24'h5a5a5a,
   parameter logic [23:0] EXT48   = 24'h010203,
   parameter logic [39:0] EXT64   = 40'h0102030405
)(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // Serial bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Status
   output logic      write_busy_o
);

   eesr_mem_if mif ();

   eesr_state_t state_q;
   eesr_lock_t  lock_q;
   eesr_space_t space_q;
   logic [3:0]  cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  ptr_q;
   logic        oe_q;
   logic        mack_q;
   logic        ee_wr_q;

   logic        sda_s;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        byte_done;
   logic        ctl_ee;
   logic        ctl_rtc;
   logic        ctl_ack;
   logic        byte_ack;
   logic        wr_done;
   logic [7:0]  rd_byte;
   eesr_space_t sp_new;

   eesr_pin_sync u_sync (
      .mclk_i     (mclk_i),
      .reset_i    (reset_i),
      .scl_pin_i  (scl_i),
      .sda_pin_i  (sda_i),
      .sda_o      (sda_s),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .start_o    (start_c),
      .stop_o     (stop_c)
   );

   eesr_mem #(
      .TWC_CYC (TWC_CYC),
      .VARIANT (VARIANT),
      .ORG_ID  (ORG_ID),
      .EXT48   (EXT48),
      .EXT64   (EXT64)
   ) u_mem (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .mif     (mif)
   );

   function automatic logic in_prot(input logic [7:0] a);
      in_prot = (a >= `EESR_PROT_LO) && (a <= `EESR_PROT_HI);
   endfunction : in_prot

   function automatic logic addr_ok(input eesr_space_t sp, input logic [7:0] a);
      if (sp == EESR_SP_EE) addr_ok = (a <= `EESR_ARR_TOP) || in_prot(a);
      else addr_ok = (a <= `EESR_RTC_TOP);
   endfunction : addr_ok

   function automatic logic [7:0] ptr_next(input eesr_space_t sp, input logic [7:0] a);
      if (sp == EESR_SP_RTC) ptr_next = (a == `EESR_RTC_TOP) ? 8'h00 : a + 8'h01;
      else if (a == `EESR_ARR_TOP) ptr_next = 8'h00;
      else if (a == `EESR_PROT_HI) ptr_next = `EESR_PROT_LO;
      else ptr_next = a + 8'h01;
   endfunction : ptr_next

   assign byte_done = scl_fall && (cnt_q == 4'h8);
   assign wr_done   = (state_q == EESR_WDAT) && byte_done;
   assign ctl_ee    = (sh_q[7:1] == `EESR_CTRL_EE);
   assign ctl_rtc   = (sh_q[7:1] == `EESR_CTRL_RTC);
   assign sp_new    = ctl_ee ? EESR_SP_EE : EESR_SP_RTC;
   assign ctl_ack   = ctl_rtc || (ctl_ee && !mif.busy);
   // Key register and clock space read zero.
   assign rd_byte   = (space_q == EESR_SP_EE) ? mif.rd_data : 8'h00;

   always_comb begin
      unique case (state_q)
         EESR_CTRL: byte_ack = ctl_ack;
         EESR_ADDR: byte_ack = addr_ok(space_q, sh_q);
         default:   byte_ack = 1'b1;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= EESR_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         oe_q    <= 1'b0;
      end else if (start_c) begin
         state_q <= EESR_CTRL;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
      end else if (stop_c) begin
         state_q <= EESR_IDLE;
         oe_q    <= 1'b0;
      end else begin
         unique case (state_q)
            EESR_IDLE: begin
               oe_q <= 1'b0;
            end
            EESR_CTRL, EESR_ADDR, EESR_WDAT: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  cnt_q <= 4'h0;
                  oe_q  <= byte_ack;
                  if (!byte_ack) state_q <= EESR_IDLE;
                  else if (state_q == EESR_CTRL) state_q <= EESR_CACK;
                  else if (state_q == EESR_ADDR) state_q <= EESR_AACK;
                  else state_q <= EESR_WACK;
               end
            end
            EESR_CACK: begin
               if (scl_fall && sh_q[0]) begin
                  state_q <= EESR_RDAT;
                  sh_q    <= rd_byte;
                  oe_q    <= ~rd_byte[7];
               end else if (scl_fall) begin
                  state_q <= EESR_ADDR;
                  oe_q    <= 1'b0;
               end
            end
            EESR_AACK, EESR_WACK: begin
               if (scl_fall) begin
                  state_q <= EESR_WDAT;
                  oe_q    <= 1'b0;
               end
            end
            EESR_RDAT: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  cnt_q   <= 4'h0;
                  oe_q    <= 1'b0;
                  state_q <= EESR_RACK;
               end else if (scl_fall) begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  oe_q <= ~sh_q[6];
               end
            end
            EESR_RACK: begin
               if (scl_fall && mack_q) begin
                  state_q <= EESR_RDAT;
                  sh_q    <= rd_byte;
                  oe_q    <= ~rd_byte[7];
               end else if (scl_fall) begin
                  // Nack releases the bus until the next start.
                  state_q <= EESR_IDLE;
               end
            end
            default: begin
               state_q <= EESR_IDLE;
               oe_q    <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mack_q <= 1'b0;
      end else if (state_q == EESR_RACK && scl_rise) begin
         mack_q <= ~sda_s;
      end
   end

   // The control byte selects the space for the whole transfer.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         space_q <= EESR_SP_EE;
      end else if (state_q == EESR_CTRL && byte_done && ctl_ack) begin
         // Same control byte reaches protected bytes.
         space_q <= sp_new;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ptr_q <= `EESR_PTR_RST;
      end else if (state_q == EESR_ADDR && byte_done && byte_ack) begin
         ptr_q <= sh_q;
      end else if (wr_done && space_q == EESR_SP_EE) begin
         ptr_q <= {ptr_q[7:3], ptr_q[2:0] + 3'h1};
      end else if (wr_done) begin
         ptr_q <= ptr_next(space_q, ptr_q);
      end else if (state_q == EESR_RDAT && byte_done) begin
         // Top of array wraps to zero.
         ptr_q <= ptr_next(space_q, ptr_q);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || stop_c) begin
         ee_wr_q <= 1'b0;
      end else if (wr_done && space_q == EESR_SP_EE) begin
         ee_wr_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         lock_q <= EESR_LOCKED;
      end else if (stop_c && ee_wr_q) begin
         lock_q <= EESR_LOCKED;
      end else if (wr_done && space_q == EESR_SP_RTC && ptr_q == `EESR_UNLOCK_ADDR) begin
         if (sh_q == `EESR_KEY1) lock_q <= EESR_KEYED;
         else if (sh_q == `EESR_KEY2 && lock_q == EESR_KEYED) lock_q <= EESR_OPEN;
         else lock_q <= EESR_LOCKED;
      end
   end

   assign mif.rd_addr = ptr_q;
   assign mif.ld      = wr_done && space_q == EESR_SP_EE &&
                        (!in_prot(ptr_q) || lock_q == EESR_OPEN);
   assign mif.ld_addr = ptr_q;
   assign mif.ld_data = sh_q;
   assign mif.clear   = (state_q == EESR_CTRL) && byte_done && ctl_ee && ctl_ack;
   // Stop begins the internal write cycle.
   assign mif.commit  = stop_c && ee_wr_q;

   assign sda_o        = 1'b0;
   assign sda_oe_o     = oe_q;
   assign write_busy_o = mif.busy;

endmodule : eesr_top

`default_nettype wire

// File: eesr_top_assertions.sv
/*
 Pin-level assertions for the serial EEPROM access block.
 Assumes one clock domain and a master that leaves the bus released when idle.
*/
`timescale 1ns/100ps
`default_nettype none

module eesr_top_chk #(
   parameter int TWC_CYC = 50000
)(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // Pins of the block
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic sda_o,
   input  wire logic sda_oe_o,
   input  wire logic write_busy_o
);
   logic [3:0]  low_q;
   logic [3:0]  stop_age_q;
   logic [31:0] busy_q;
   logic        sda_q;
   logic        frame_q;
   logic        stop_w;
   logic        start_w;

   assign stop_w  = scl_i && sda_i && !sda_q;
   assign start_w = scl_i && !sda_i && sda_q;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sda_q   <= 1'b1;
         frame_q <= 1'b0;
      end else begin
         sda_q   <= sda_i;
         frame_q <= start_w | (frame_q & !stop_w);
      end
   end

   // Saturating ages keep the helper small on long idle stretches.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         low_q      <= 4'h0;
         stop_age_q <= 4'hf;
         busy_q     <= 32'h0;
      end else begin
         low_q      <= scl_i ? 4'h0 : ((low_q == 4'hf) ? low_q : low_q + 4'h1);
         stop_age_q <= stop_w ? 4'h0 : ((stop_age_q == 4'hf) ? stop_age_q : stop_age_q + 4'h1);
         busy_q     <= write_busy_o ? busy_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_open_drain: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("data drive changed while clock high");
   a_oe_delay: assert property ($changed(sda_oe_o) |-> low_q >= 4'h1 && low_q <= 4'h5)
      else $error("data drive changed outside its slot");
   a_oe_in_frame: assert property (sda_oe_o |-> frame_q)
      else $error("data driven outside a transfer");
   a_quiet_stop: assert property (stop_w |=> !sda_oe_o [*4])
      else $error("data driven after stop");
   a_busy_after_stop: assert property ($rose(write_busy_o) |-> stop_age_q <= 4'h8)
      else $error("write cycle began without stop");
   a_busy_hold: assert property ($rose(write_busy_o) |=> write_busy_o [*8])
      else $error("write cycle ended early");
   a_busy_length: assert property ($fell(write_busy_o) |->
      busy_q >= TWC_CYC && busy_q <= TWC_CYC + 1)
      else $error("write cycle length wrong");

   c_busy: cover property ($rose(write_busy_o));
   c_drive: cover property ($rose(sda_oe_o));
   c_stop: cover property (stop_w);
endmodule : eesr_top_chk

bind eesr_top eesr_top_chk #(.TWC_CYC(TWC_CYC)) u_eesr_top_chk (
   .mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_busy_o(write_busy_o));

`default_nettype wire

// File: eesr_master.sv
/*
 Behavioural bus master for the EEPROM block; reports each acknowledge and
 received byte on a one-cycle strobe.
 Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

module eesr_master (
   // Clock
   input  wire logic  mclk_i,
   // Bus pins
   input  wire logic  sda_i,
   output logic       scl_o,
   output logic       pull_o,
   // Observed results
   output logic       evt_o,
   output logic [8:0] evt_d_o
);
   initial begin
      scl_o   = 1'b1;
      pull_o  = 1'b0;
      evt_o   = 1'b0;
      evt_d_o = 9'h000;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : wait_n

   task automatic note(input logic [8:0] v);
      evt_d_o = v;
      evt_o   = 1'b1;
      wait_n(1);
      evt_o   = 1'b0;
   endtask : note

   // Data moves only while the clock is low, with three cycles of setup.
   task automatic bit_io(input logic b, output logic r);
      wait_n(1);
      pull_o = !b;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      r = sda_i;
      scl_o = 1'b0;
   endtask : bit_io

   // Start or repeated start: data falls while the clock is high.
   task automatic frame_begin();
      wait_n(1);
      pull_o = 1'b0;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      pull_o = 1'b1;
      wait_n(6);
      scl_o = 1'b0;
   endtask : frame_begin

   // Stop: data rises while the clock is high, and the clock is left high after it.
   task automatic frame_end();
      wait_n(1);
      pull_o = 1'b1;
      wait_n(3);
      scl_o = 1'b1;
      wait_n(4);
      pull_o = 1'b0;
      wait_n(6);
   endtask : frame_end

   task automatic wbyte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      note({8'h80, r});
   endtask : wbyte

   task automatic rbyte(input logic ack);
      logic [7:0] d;
      logic       r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
      note({1'b0, d});
   endtask : rbyte
endmodule : eesr_master

`default_nettype wire

// File: eesr_top_bench.sv
/*
 Self-checking bench for the EEPROM access block, driven through a master model.
 Assumes the write cycle is shortened through TWC_CYC.
*/
`timescale 1ns/100ps
`default_nettype none
`include "eesr_params.svh"

module eesr_top_bench;
   localparam int          TWC = 400;
   // Identifier values are arbitrary.
   localparam logic [23:0] ORG = 24'h3c5a96;
   // The extension starts with a reserved prefix, which the store must clear.
   localparam logic [39:0] EXT = 40'hfffe334455;
   localparam logic [7:0]  BAD [4] = '{8'h80, 8'hef, 8'hf8, 8'h60};
   localparam logic [15:0] KEYS [3] = '{16'h0000, 16'h5512, 16'haa55};
   logic       mclk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       scl, pull, evt, sda_o, sda_oe_o, write_busy_o;
   logic [8:0] evt_d;
   logic [8:0] exp_q [$];
   logic [7:0] wd [8];
   logic [7:0] img [8];
   logic [7:0] ed [9];
   int         n_mismatch = 0;
   int         comparisons = 0;
   // Pulled-up wire: low while the master pulls it or the block drives its data value.
   wire logic  sda = !pull && (!sda_oe_o || sda_o);

   always #50 mclk_i = ~mclk_i;

   eesr_top #(.TWC_CYC(TWC), .VARIANT(2), .ORG_ID(ORG), .EXT64(EXT)) u_eesr_top (
      .mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_busy_o(write_busy_o));
   eesr_master u_eesr_master (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull),
      .evt_o(evt), .evt_d_o(evt_d));

   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      comparisons++;
      if (seen !== want) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge mclk_i) begin
      if (evt === 1'b1) check(evt_d, (exp_q.size() > 0) ? exp_q.pop_front() : 9'hxxx);
   end

   task automatic wr(input logic [6:0] c, input logic [7:0] a, input int n, input logic an);
      exp_q.push_back(9'h100);
      u_eesr_master.frame_begin();
      u_eesr_master.wbyte({c, 1'b0});
      exp_q.push_back({8'h80, an});
      u_eesr_master.wbyte(a);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(9'h100);
         u_eesr_master.wbyte(wd[i]);
      end
      u_eesr_master.frame_end();
   endtask : wr

   task automatic rd(input logic [6:0] c, input logic [7:0] a, input int n);
      for (int i = 0; i < 3; i++) exp_q.push_back(9'h100);
      u_eesr_master.frame_begin();
      u_eesr_master.wbyte({c, 1'b0});
      u_eesr_master.wbyte(a);
      u_eesr_master.frame_begin();
      u_eesr_master.wbyte({c, 1'b1});
      for (int i = 0; i < n; i++) begin
         exp_q.push_back({1'b0, ed[i]});
         u_eesr_master.rbyte(i < n - 1);
      end
      u_eesr_master.frame_end();
   endtask : rd

   task automatic probe(input logic [6:0] c, input logic nack);
      exp_q.push_back({8'h80, nack});
      u_eesr_master.frame_begin();
      u_eesr_master.wbyte({c, 1'b0});
      u_eesr_master.frame_end();
   endtask : probe

   task automatic key(input logic [7:0] k);
      wd[0] = k;
      wr(`EESR_CTRL_RTC, `EESR_UNLOCK_ADDR, 1, 1'b0);
   endtask : key

   task automatic busy_wait();
      check({8'h00, write_busy_o}, 9'h001);
      repeat (TWC + 8) @(negedge mclk_i);
   endtask : busy_wait

   initial begin
      void'($urandom(62645));
      for (int i = 0; i < 8; i++) img[i] = 8'({ORG, 16'h0000, EXT[23:0]} >> (56 - 8 * i));
      repeat (16) @(negedge mclk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      for (int i = 0; i < 9; i++) ed[i] = img[i % 8];
      rd(`EESR_CTRL_EE, `EESR_PROT_LO, 9);
      $display("test 1 done");
      wd[0] = 8'($urandom);
      ed[2] = wd[0];
      wr(`EESR_CTRL_EE, 8'h00, 1, 1'b0);
      busy_wait();
      for (int i = 0; i < 3; i++) wd[i] = 8'($urandom);
      ed[0] = wd[0];
      ed[1] = wd[1];
      ed[3] = wd[2];
      wr(`EESR_CTRL_EE, 8'h7e, 3, 1'b0);
      check({8'h00, write_busy_o}, 9'h001);
      probe(`EESR_CTRL_RTC, 1'b0);
      probe(`EESR_CTRL_EE, 1'b1);
      repeat (TWC) @(negedge mclk_i);
      rd(`EESR_CTRL_EE, 8'h7e, 3);
      ed[0] = ed[3];
      rd(`EESR_CTRL_EE, 8'h78, 1);
      $display("test 2 done");
      for (int i = 0; i < 4; i++) wr((i < 3) ? `EESR_CTRL_EE : `EESR_CTRL_RTC, BAD[i], 0, 1'b1);
      key(`EESR_KEY1);
      ed[0] = 8'h00;
      rd(`EESR_CTRL_RTC, `EESR_UNLOCK_ADDR, 1);
      $display("test 3 done");
      for (int k = 0; k < 3; k++) begin
         key(KEYS[k][15:8]);
         key(KEYS[k][7:0]);
         wd[0] = ~img[0];
         wr(`EESR_CTRL_EE, `EESR_PROT_LO, 1, 1'b0);
         check({8'h00, write_busy_o}, 9'h000);
         ed[0] = img[0];
         rd(`EESR_CTRL_EE, `EESR_PROT_LO, 1);
      end
      $display("test 4 done");
      key(`EESR_KEY1);
      key(`EESR_KEY2);
      wd[0] = 8'($urandom);
      wd[1] = 8'($urandom);
      img[3] = wd[0];
      img[4] = wd[1];
      wr(`EESR_CTRL_EE, 8'hf3, 2, 1'b0);
      busy_wait();
      wd[0] = ~img[3];
      wr(`EESR_CTRL_EE, 8'hf3, 1, 1'b0);
      check({8'h00, write_busy_o}, 9'h000);
      for (int i = 0; i < 8; i++) ed[i] = img[i];
      rd(`EESR_CTRL_EE, `EESR_PROT_LO, 8);
      $display("test 5 done");
      check(9'(exp_q.size()), 9'h000);
      report_and_stop();
   end

   initial begin
      repeat (60000) @(posedge mclk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule : eesr_top_bench

`default_nettype wire
